//--- hdl/adc_ctl_pkg.sv
// Constants and types shared by the serial converter control block
package adc_ctl_pkg;
  // Buffer shape
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FIFO_FULL = 5'h10;
  // Result is 10 bits plus 2 sub-bits, sample is signed
  localparam int RES_W = 12;
  localparam int SMP_W = 13;
  // Command byte decode
  localparam int CMD_CONV_BIT = 7;
  localparam int CMD_SETUP_BIT = 6;
  localparam int CMD_AVG_BIT = 5;
  localparam int MODE_HI_BIT = 5;
  localparam int MODE_LO_BIT = 4;
  localparam int CH_HI = 6;
  localparam int CH_LO = 3;
  localparam int SCAN_HI = 2;
  localparam int SCAN_LO = 1;
  localparam int TEMP_BIT = 0;
  localparam int DSEL_HI = 1;
  localparam int DSEL_LO = 0;
  localparam int NSCAN_HI = 1;
  localparam int NSCAN_LO = 0;
  // Clock modes
  localparam logic [1:0] MODE_STB_SCAN = 2'h0;
  localparam logic [1:0] MODE_STB_EACH = 2'h1;
  localparam logic [1:0] MODE_SERIAL = 2'h2;
  localparam logic [1:0] MODE_SCLK = 2'h3;
  localparam logic [1:0] MODE_RESET = MODE_SERIAL;
  // Scan modes
  localparam logic [1:0] SCAN_UP_TO = 2'h0;
  localparam logic [1:0] SCAN_FROM = 2'h1;
  localparam logic [1:0] SCAN_REPEAT = 2'h2;
  localparam logic [1:0] SCAN_SINGLE = 2'h3;
  localparam logic [3:0] CH_LAST = 4'hF;
  // Repeat count is NSCAN * REP_UNIT + REP_UNIT
  localparam logic [CNT_W-1:0] REP_UNIT = 5'h04;
  // Reset values
  localparam logic [7:0] PAIR_RESET = 8'h00;
  localparam logic [6:0] CONV_RESET = 7'h00;
  localparam logic [1:0] NSCAN_RESET = 2'h0;
  // Host clock limits, for the bench
  localparam int SCLK_MAX_HZ = 10_000_000;
  localparam int SCLK_EXT_MAX_HZ = 4_800_000;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_REQ = 4'h2,
    ST_WAIT = 4'h4,
    ST_HOLD = 4'h8
  } seq_state_t;
endpackage

//--- hdl/adc_serial_control_fifo.sv
// Serial port, conversion sequencer and result buffer of the converter
//
// Operation
// - Input bits are captured on rising serial clock while selected.
// - Output bit changes on each falling serial clock edge.
// - Bipolar and temperature results are two's complement, others binary.
// - Each frame opens with an 8-bit command byte, MSB first.
// - Byte after setup byte goes to the addressed pairing register.
// - Setup bits 5 and 4 select one of four clock modes.
// - Mode 00: strobe low pulse runs the whole programmed sequence.
// - Mode 01: each strobe converts one channel only.
// - Mode 10 is the reset default; conversion byte starts conversions.
// - Mode 11 is timed by the serial clock, up to 4.8MHz.
// - Mode 11 ignores scan and averaging settings.
// - Modes 00 and 10: done goes low after the last conversion.
// - Mode 01: done goes low after every conversion.
// - Done rises on select falling, or on strobe falling in modes 00/01; always high in mode 11.
// - Pairs are even/odd neighbours, even channel positive.
// - Setup low bits address pairing register; 1 makes pair differential.
// - Negative unipolar differential input codes as zero.
// - Sixteen results plus one temperature; overflow overwrites oldest.
// - Result is two bytes: 4 zeros, 10 bits, 2 sub-bits.
// - Oldest unread byte shifts out MSB first; zeros when empty.
// - Temperature is read first; a newer one replaces the older.
// - Command byte with MSB set writes the conversion register.
// - Modes 10/11 start by register write, 00/01 by strobe.
`timescale 1ns/1ns
module adc_serial_control_fifo
  import adc_ctl_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic reset_n_i, // Async reset, active low
  input wire logic sclk_i, // Serial clock from host
  input wire logic cs_n_i, // Chip select, active low
  input wire logic din_i, // Serial data in
  output logic dout_o, // Serial data out
  output logic dout_oe_n_o, // Data out enable, low drives
  input wire logic convert_strobe_n_i, // Conversion strobe, active low
  output logic done_n_o, // End of conversion, active low
  output logic osc_en_o, // Internal oscillator enable
  output logic timing_mode_sel_hi_o, // Clock mode, high bit
  output logic timing_mode_sel_lo_o, // Clock mode, low bit
  output logic conv_req_o, // Conversion request pulse
  output logic [3:0] conv_chan_o, // Positive input channel
  output logic conv_diff_o, // Differential pair selected
  output logic conv_temp_o, // Temperature measurement
  input wire logic conv_ack_i, // Conversion finished pulse
  input wire logic [SMP_W-1:0] conv_sample_i // Signed sample
);

  // Pair bit of a channel: pair p sits at bit 7-p
  function automatic logic pair_bit(input logic [7:0] r, input logic [3:0] ch);
    pair_bit = r[~ch[3:1]];
  endfunction

  // Result coding from the signed sample
  function automatic logic [RES_W-1:0] code_result(
    input logic [SMP_W-1:0] s,
    input logic bip
  );
    logic [SMP_W-1:0] half;
    half = {s[SMP_W-1], s[SMP_W-1:1]};
    if (bip) begin
      code_result = half[RES_W-1:0];
    end else if (s[SMP_W-1]) begin
      code_result = '0;
    end else begin
      code_result = s[RES_W-1:0];
    end
  endfunction

  // Link side state
  logic link_clr;
  logic [2:0] bit_cnt_r;
  logic [6:0] rx_sh_r;
  logic [7:0] rx_byte_r;
  logic rx_tgl_r;
  logic [7:0] tx_sh_r;
  logic pop_tgl_r;
  // System side state
  logic [2:0] rx_sync_r;
  logic [2:0] pop_sync_r;
  logic [2:0] cs_sync_r;
  logic [2:0] stb_sync_r;
  logic rx_evt;
  logic pop_evt;
  logic cs_fall;
  logic cs_high;
  logic stb_fall;
  logic [1:0] mode_r;
  logic [7:0] uni_r;
  logic [7:0] bip_r;
  logic [6:0] conv_r;
  logic [1:0] nscan_r;
  logic pair_pend_r;
  logic pair_sel_r;
  logic start_ser_r;
  seq_state_t state_r;
  logic [3:0] ch_r;
  logic [3:0] end_ch_r;
  logic [CNT_W-1:0] rep_r;
  logic rep_mode_r;
  logic temp_pend_r;
  logic done_n_r;
  logic cur_diff;
  logic cur_bip;
  logic [4:0] next_ch;
  logic last_conv;
  logic ack_conv;
  logic ack_temp;
  logic trig;
  logic [1:0] scan_sel;
  logic [3:0] chsel;
  logic [RES_W-1:0] mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] count_r;
  logic [RES_W-1:0] temp_r;
  logic temp_valid_r;
  logic phase_r;
  logic refresh_r;
  logic [7:0] tx_word_r;
  logic fifo_full;
  logic head_valid;
  logic rm_fifo;
  logic rm_temp;
  logic [RES_W-1:0] head_word;
  logic [7:0] head_byte;

  // Link logic is cleared whenever the host deselects the device
  assign link_clr = cs_n_i | ~reset_n_i;

  // Bit counter and input shifter on rising host clock
  always_ff @(posedge sclk_i or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt_r <= 3'h0;
      rx_sh_r <= 7'h00;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      rx_sh_r <= {rx_sh_r[5:0], din_i};
    end
  end

  // Completed byte, held stable for eight clocks, with event toggle
  always_ff @(posedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_byte_r <= 8'h00;
      rx_tgl_r <= 1'b0;
    end else if (bit_cnt_r == 3'h7) begin
      rx_byte_r <= {rx_sh_r, din_i};
      rx_tgl_r <= ~rx_tgl_r;
    end
  end

  // Output shifter on falling host clock; loads after first bit
  always_ff @(negedge sclk_i or posedge link_clr) begin
    if (link_clr) begin
      tx_sh_r <= 8'h00;
    end else if (bit_cnt_r == 3'h1) begin
      tx_sh_r <= {tx_word_r[6:0], 1'b0};
    end else begin
      tx_sh_r <= {tx_sh_r[6:0], 1'b0};
    end
  end

  // Byte taken event back to the system side
  always_ff @(negedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pop_tgl_r <= 1'b0;
    end else if (bit_cnt_r == 3'h1) begin
      pop_tgl_r <= ~pop_tgl_r;
    end
  end

  // First bit of a byte comes straight from the staged word
  assign dout_o = (bit_cnt_r == 3'h0) ? tx_word_r[7] : tx_sh_r[7];
  assign dout_oe_n_o = cs_n_i;

  // Synchronisers for events and pins
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_sync_r <= 3'h0;
      pop_sync_r <= 3'h0;
      cs_sync_r <= 3'h7;
      stb_sync_r <= 3'h7;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], rx_tgl_r};
      pop_sync_r <= {pop_sync_r[1:0], pop_tgl_r};
      cs_sync_r <= {cs_sync_r[1:0], cs_n_i};
      stb_sync_r <= {stb_sync_r[1:0], convert_strobe_n_i};
    end
  end

  assign rx_evt = rx_sync_r[2] ^ rx_sync_r[1];
  assign pop_evt = pop_sync_r[2] ^ pop_sync_r[1];
  assign cs_fall = cs_sync_r[2] & ~cs_sync_r[1];
  assign cs_high = cs_sync_r[1];
  // Strobe only counts in the strobe-driven modes
  assign stb_fall = stb_sync_r[2] & ~stb_sync_r[1] & ~mode_r[1];

  // Command decode and configuration registers
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_r <= MODE_RESET;
      uni_r <= PAIR_RESET;
      bip_r <= PAIR_RESET;
      conv_r <= CONV_RESET;
      nscan_r <= NSCAN_RESET;
      pair_pend_r <= 1'b0;
      pair_sel_r <= 1'b0;
    end else if (rx_evt) begin
      if (pair_pend_r) begin
        pair_pend_r <= 1'b0;
        if (pair_sel_r) begin
          bip_r <= rx_byte_r;
        end else begin
          uni_r <= rx_byte_r;
        end
      end else if (rx_byte_r[CMD_CONV_BIT]) begin
        conv_r <= rx_byte_r[6:0];
      end else if (rx_byte_r[CMD_SETUP_BIT]) begin
        mode_r <= rx_byte_r[MODE_HI_BIT:MODE_LO_BIT];
        pair_pend_r <= rx_byte_r[DSEL_HI];
        pair_sel_r <= rx_byte_r[DSEL_LO];
      end else if (rx_byte_r[CMD_AVG_BIT]) begin
        nscan_r <= rx_byte_r[NSCAN_HI:NSCAN_LO];
      end
    end else if (cs_fall) begin
      pair_pend_r <= 1'b0;
    end
  end

  // Conversion byte starts a sequence in the serially driven modes
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      start_ser_r <= 1'b0;
    end else begin
      start_ser_r <= rx_evt & ~pair_pend_r & rx_byte_r[CMD_CONV_BIT] & mode_r[1];
    end
  end

  // Current channel decode and step
  assign cur_diff = pair_bit(uni_r, ch_r) | pair_bit(bip_r, ch_r);
  assign cur_bip = pair_bit(bip_r, ch_r);
  assign next_ch = {1'b0, ch_r} + (cur_diff ? 5'h02 : 5'h01);
  assign last_conv = rep_mode_r ? (rep_r == 5'h01) : (next_ch > {1'b0, end_ch_r});
  assign ack_conv = (state_r == ST_WAIT) & conv_ack_i & ~temp_pend_r;
  assign ack_temp = (state_r == ST_WAIT) & conv_ack_i & temp_pend_r;
  assign trig = start_ser_r | stb_fall;
  // Sample-clocked mode converts channel N once only
  assign scan_sel = (mode_r == MODE_SCLK) ? SCAN_SINGLE : conv_r[SCAN_HI:SCAN_LO];
  assign chsel = conv_r[CH_HI:CH_LO];

  // Conversion sequencer
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
      ch_r <= 4'h0;
      end_ch_r <= 4'h0;
      rep_r <= 5'h01;
      rep_mode_r <= 1'b0;
      temp_pend_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (trig) begin
            ch_r <= (scan_sel == SCAN_UP_TO) ? 4'h0 : chsel;
            end_ch_r <= (scan_sel == SCAN_FROM) ? CH_LAST : chsel;
            rep_mode_r <= (scan_sel == SCAN_REPEAT);
            rep_r <= {1'b0, nscan_r, 2'h0} + REP_UNIT;
            temp_pend_r <= conv_r[TEMP_BIT];
            state_r <= ST_REQ;
          end
        end
        ST_REQ: begin
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (ack_temp) begin
            temp_pend_r <= 1'b0;
            state_r <= ST_REQ;
          end else if (ack_conv) begin
            if (last_conv) begin
              state_r <= ST_IDLE;
            end else begin
              rep_r <= rep_r - 5'h01;
              ch_r <= rep_mode_r ? ch_r : next_ch[3:0];
              // One channel per strobe in mode 01
              state_r <= (mode_r == MODE_STB_EACH) ? ST_HOLD : ST_REQ;
            end
          end
        end
        ST_HOLD: begin
          if (stb_fall) begin
            state_r <= ST_REQ;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Request to the analog front end, one cycle after the request state
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      conv_req_o <= 1'b0;
      conv_chan_o <= 4'h0;
      conv_diff_o <= 1'b0;
      conv_temp_o <= 1'b0;
    end else begin
      conv_req_o <= (state_r == ST_REQ);
      if (state_r == ST_REQ) begin
        conv_chan_o <= cur_diff ? {ch_r[3:1], 1'b0} : ch_r;
        conv_diff_o <= cur_diff;
        conv_temp_o <= temp_pend_r;
      end
    end
  end

  // End-of-conversion flag; completion wins over a clearing edge
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_n_r <= 1'b1;
    end else if (mode_r == MODE_SCLK) begin
      done_n_r <= 1'b1;
    end else if (ack_conv & (last_conv | (mode_r == MODE_STB_EACH))) begin
      done_n_r <= 1'b0;
    end else if (cs_fall | stb_fall) begin
      done_n_r <= 1'b1;
    end
  end

  assign done_n_o = done_n_r;
  assign osc_en_o = (mode_r != MODE_SCLK);
  assign timing_mode_sel_hi_o = mode_r[1];
  assign timing_mode_sel_lo_o = mode_r[0];

  // Result buffer bookkeeping
  assign fifo_full = (count_r == FIFO_FULL);
  assign head_valid = temp_valid_r | (count_r != 5'h00);
  assign rm_temp = pop_evt & phase_r & temp_valid_r;
  assign rm_fifo = pop_evt & phase_r & ~temp_valid_r & (count_r != 5'h00);

  // Result storage
  always_ff @(posedge clk_sys_i) begin
    if (ack_conv) begin
      mem[wr_ptr_r] <= code_result(conv_sample_i, cur_bip);
    end
  end

  // Pointers and fill count; a full buffer drops its oldest entry
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_r <= 4'h0;
      rd_ptr_r <= 4'h0;
      count_r <= 5'h00;
    end else begin
      if (ack_conv) begin
        wr_ptr_r <= wr_ptr_r + 4'h1;
      end
      if (rm_fifo | (ack_conv & fifo_full)) begin
        rd_ptr_r <= rd_ptr_r + 4'h1;
      end
      if (ack_conv & ~fifo_full & ~rm_fifo) begin
        count_r <= count_r + 5'h01;
      end else if (rm_fifo & ~ack_conv) begin
        count_r <= count_r - 5'h01;
      end
    end
  end

  // Temperature entry; a new result wins over a clear
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      temp_r <= 12'h000;
      temp_valid_r <= 1'b0;
    end else if (ack_temp) begin
      temp_r <= conv_sample_i[RES_W-1:0];
      temp_valid_r <= 1'b1;
    end else if (rm_temp) begin
      temp_valid_r <= 1'b0;
    end
  end

  // Head of read-out: temperature first, then oldest result
  assign head_word = temp_valid_r ? temp_r : mem[rd_ptr_r];
  assign head_byte = !head_valid ? 8'h00 :
                     phase_r ? head_word[7:0] : {4'h0, head_word[RES_W-1:8]};

  // Byte phase advances each time the link takes a byte while a result is pending
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_r <= 1'b0;
      refresh_r <= 1'b0;
    end else begin
      refresh_r <= pop_evt;
      if (pop_evt & head_valid) begin
        phase_r <= ~phase_r;
      end
    end
  end

  // Staged byte for the link; changes only when the link is idle
  // or right after it took the previous byte
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_word_r <= 8'h00;
    end else if (cs_high | refresh_r) begin
      tx_word_r <= head_byte;
    end
  end

endmodule

//--- testbench/adc_ctl_sva.sv
// Assertion checker for the converter control block
`timescale 1ns/1ns
module adc_ctl_sva (
  input wire logic clk_sys_i, // System clock
  input wire logic reset_n_i, // Reset, active low
  input wire logic cs_n_i, // Chip select
  input wire logic dout_oe_n_o, // Data out enable
  input wire logic convert_strobe_n_i, // Strobe
  input wire logic done_n_o, // Done flag
  input wire logic osc_en_o, // Oscillator enable
  input wire logic timing_mode_sel_hi_o, // Mode high bit
  input wire logic timing_mode_sel_lo_o, // Mode low bit
  input wire logic conv_req_o, // Request pulse
  input wire logic [3:0] conv_chan_o, // Channel
  input wire logic conv_diff_o, // Pair flag
  input wire logic conv_ack_i // Finished pulse
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  wire m11 = timing_mode_sel_hi_o && timing_mode_sel_lo_o;
  // Building blocks
  sequence s_req_pulse;
    conv_req_o ##1 !conv_req_o;
  endsequence
  sequence s_cs_fall;
    $fell(cs_n_i);
  endsequence
  // Port and flag relations
  a_oe_follows_cs: assert property (dout_oe_n_o == cs_n_i)
    else $error("data enable differs from select");
  a_osc_by_mode: assert property (osc_en_o == !m11)
    else $error("oscillator enable wrong for mode");
  a_done_mode11: assert property (m11 |-> done_n_o)
    else $error("done low in serial clock mode");
  a_done_cs_rise: assert property (s_cs_fall |-> ##[1:6] done_n_o)
    else $error("done not raised by select");
  a_done_stb_rise: assert property (!timing_mode_sel_hi_o && $fell(convert_strobe_n_i)
    |-> ##[1:6] done_n_o)
    else $error("done not raised by strobe");
  a_done_after_ack: assert property ($fell(done_n_o) |-> $past(conv_ack_i))
    else $error("done fell without a finished conversion");
  // Front end request shape
  a_req_one_cycle: assert property (conv_req_o |-> s_req_pulse)
    else $error("request longer than one cycle");
  a_chan_hold: assert property ($changed(conv_chan_o) |-> conv_req_o)
    else $error("channel changed without request");
  a_diff_even: assert property (conv_req_o && conv_diff_o |-> !conv_chan_o[0])
    else $error("pair request on odd channel");
endmodule
bind adc_serial_control_fifo adc_ctl_sva u_sva (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i),
  .dout_oe_n_o(dout_oe_n_o), .convert_strobe_n_i(convert_strobe_n_i),
  .done_n_o(done_n_o), .osc_en_o(osc_en_o),
  .timing_mode_sel_hi_o(timing_mode_sel_hi_o),
  .timing_mode_sel_lo_o(timing_mode_sel_lo_o), .conv_req_o(conv_req_o),
  .conv_chan_o(conv_chan_o), .conv_diff_o(conv_diff_o), .conv_ack_i(conv_ack_i));

//--- testbench/host_master.sv
// Serial host model that frames bytes on the four-wire port
`timescale 1ns/1ns
module host_master (
  output logic sclk_o, // Serial clock, idles low
  output logic cs_n_o, // Chip select
  output logic din_o, // Data to device
  input wire logic dout_i // Data from device
);
  localparam int HALF = 24;
  // Idle: clock low with polarity equal to phase
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // Select falls before the first clock edge
  task automatic open_f();
    #(HALF) cs_n_o = 1'b0;
    #(HALF);
  endtask
  // One byte MSB first, data set while clock low, read on rising
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      din_o = tx[i];
      #(HALF) sclk_o = 1'b1;
      rx[i] = dout_i;
      #(HALF) sclk_o = 1'b0;
    end
  endtask
  // Released data line shows the inverse of its last level
  task automatic close_f();
    #(HALF) cs_n_o = 1'b1;
    din_o = ~din_o;
  endtask
endmodule

//--- testbench/adc_serial_control_fifo_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module adc_serial_control_fifo_tb;
  import adc_ctl_pkg::*;
  logic clk_sys_i, reset_n_i, sclk_i, cs_n_i, din_i, dout_o, dout_oe_n_o;
  logic convert_strobe_n_i, done_n_o, osc_en_o, mhi, mlo, conv_req_o;
  logic conv_diff_o, conv_temp_o, conv_ack_i;
  logic [3:0] conv_chan_o;
  logic [SMP_W-1:0] conv_sample_i;
  logic [SMP_W-1:0] smp_q[$];
  logic [5:0] log_q[$];
  logic [7:0] rx;
  int fe_wait = 0, bad_count = 0, tests_run = 0;

  adc_serial_control_fifo dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i), .dout_o(dout_o),
    .dout_oe_n_o(dout_oe_n_o), .convert_strobe_n_i(convert_strobe_n_i),
    .done_n_o(done_n_o), .osc_en_o(osc_en_o), .timing_mode_sel_hi_o(mhi),
    .timing_mode_sel_lo_o(mlo), .conv_req_o(conv_req_o), .conv_chan_o(conv_chan_o),
    .conv_diff_o(conv_diff_o), .conv_temp_o(conv_temp_o), .conv_ack_i(conv_ack_i),
    .conv_sample_i(conv_sample_i));
  host_master host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i), .dout_i(dout_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Front end: logs each request, finishes it four cycles later
  always @(posedge clk_sys_i) begin
    #1;
    conv_ack_i = 1'b0;
    if (conv_req_o === 1'b1) begin
      log_q.push_back({conv_temp_o, conv_diff_o, conv_chan_o});
      fe_wait = 4;
    end else if (fe_wait > 0) begin
      fe_wait--;
      if (fe_wait == 0) begin
        conv_ack_i = 1'b1;
        conv_sample_i = (smp_q.size() > 0) ? smp_q.pop_front() : '0;
      end
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic lg(input int i, input logic [5:0] e);
    chk({2'b00, log_q[i]}, {2'b00, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic frame(input logic [7:0] a, input logic [7:0] b, input int n);
    host.open_f();
    host.xfer(a, rx);
    if (n > 1) host.xfer(b, rx);
    host.close_f();
    cyc(8);
  endtask
  task automatic rd(input logic [7:0] e[$]);
    host.open_f();
    foreach (e[i]) begin
      host.xfer(8'h00, rx);
      chk(rx, e[i]);
    end
    host.close_f();
    cyc(8);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done_n_o !== 1'b0 && n < 2000) begin
      cyc(1);
      n++;
    end
    chk({7'h0, done_n_o}, 8'h00);
  endtask
  task automatic strobe();
    @(posedge clk_sys_i) #1 convert_strobe_n_i = 1'b0;
    cyc(3);
    convert_strobe_n_i = 1'b1;
    cyc(4);
  endtask
  task automatic t_reset();
    chk({6'h0, mhi, mlo}, 8'h02);
    chk({7'h0, osc_en_o}, 8'h01);
    chk({7'h0, done_n_o}, 8'h01);
  endtask
  task automatic t_mode11();
    log_q.delete();
    frame(8'h70, 8'h00, 1);
    chk({6'h0, mhi, mlo}, 8'h03);
    chk({7'h0, osc_en_o}, 8'h00);
    smp_q = '{13'h0044};
    frame(8'h90, 8'h00, 1);
    cyc(30);
    chk(8'(log_q.size()), 8'h01);
    lg(0, 6'h02);
    chk({7'h0, done_n_o}, 8'h01);
    rd('{8'h00, 8'h44});
    frame(8'h60, 8'h00, 1);
    chk({6'h0, mhi, mlo}, 8'h02);
  endtask
  task automatic t_temp();
    log_q.delete();
    smp_q = '{13'h1F38, 13'h1FF0};
    frame(8'hAF, 8'h00, 1);
    repeat (200) if (log_q.size() < 2) cyc(1);
    chk({7'h0, done_n_o}, 8'h01);
    wait_done();
    chk({7'h0, log_q[0][5]}, 8'h01);
    lg(1, 6'h05);
    rd('{8'h0F, 8'h38, 8'h00, 8'h00, 8'h00});
  endtask
  task automatic t_pair();
    log_q.delete();
    frame(8'h63, 8'h80, 2);
    frame(8'h62, 8'h40, 2);
    smp_q = '{13'h1F00, 13'h1800};
    frame(8'h86, 8'h00, 1);
    wait_done();
    // Read before the next command frame, which would take a byte
    rd('{8'h0F, 8'h80});
    frame(8'h9E, 8'h00, 1);
    wait_done();
    lg(0, 6'h10);
    lg(1, 6'h12);
    rd('{8'h00, 8'h00, 8'h00});
  endtask
  // Repeat scan sized by the averaging byte, then a scan to the top channel
  task automatic t_scan();
    logic [7:0] z[$];
    repeat (16) z.push_back(8'h00);
    log_q.delete();
    frame(8'h21, 8'h00, 1);
    frame(8'hCC, 8'h00, 1);
    wait_done();
    chk(8'(log_q.size()), 8'h08);
    lg(7, 6'h09);
    rd(z);
    log_q.delete();
    smp_q = '{13'h0001, 13'h0002, 13'h0003, 13'h0004};
    frame(8'hE2, 8'h00, 1);
    wait_done();
    chk(8'(log_q.size()), 8'h04);
    lg(0, 6'h0C);
    lg(3, 6'h0F);
    rd('{8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h03, 8'h00, 8'h04, 8'h00});
  endtask
  task automatic t_stb();
    log_q.delete();
    frame(8'h40, 8'h00, 1);
    frame(8'hA0, 8'h00, 1);
    cyc(20);
    chk(8'(log_q.size()), 8'h00);
    smp_q = '{13'h0010, 13'h0010, 13'h0020};
    strobe();
    wait_done();
    lg(0, 6'h10);
    lg(1, 6'h12);
    lg(2, 6'h04);
    rd('{8'h00, 8'h08, 8'h00, 8'h10, 8'h00, 8'h20});
    log_q.delete();
    frame(8'h50, 8'h00, 1);
    strobe();
    wait_done();
    chk(8'(log_q.size()), 8'h01);
    strobe();
    wait_done();
    chk(8'(log_q.size()), 8'h02);
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run time
  initial begin
    #300_000;
    bad_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    reset_n_i = 1'b0;
    convert_strobe_n_i = 1'b1;
    repeat (5) @(posedge clk_sys_i);
    #1 reset_n_i = 1'b1;
    cyc(4);
    t_reset();
    t_mode11();
    t_temp();
    t_pair();
    t_scan();
    t_stb();
    end_sim();
  end
endmodule
